// ===== rtl/ssd_core.sv
// Byte-wide synchronous serial interface core, controller or peripheral.
// Assumes one bus clock; all link pins are asynchronous and filtered here.
// Operation
// - Half serial period is (preselect+1) times 2^select bus clocks; divisor 2..2048.
// - Status reads anytime; writes to status change nothing.
// - Receive-complete flag sets once a received byte lands in the data buffer.
// - Receive-complete clears on data read after a status read that saw it set.
// - Transmit-empty flag reads 1 while the transmit buffer is empty.
// - Data write loads transmit only after status read saw transmit-empty set.
// - Mode fault sets when select goes low as controller with detection on and select output off.
// - Mode fault clears on control one write after a status read saw it.
// - One data address: reads return receive buffer, writes go to transmit.
// - As controller, a queued byte starts right after the previous transfer.
// - Received byte stays readable until the next transfer ends.
// - Unserviced receive flag drops new bytes; buffer keeps the first one.
// - Port enable dedicates clock, controller-out and peripheral-out pins; select too, except as controller with fault detection off.
// - Both 8-bit shifters form a 16-bit ring shifted eight places per byte.
// - Idle level inverts the clock; edge select picks odd or even sampling.
// - Controller select set means controller mode, clear means peripheral mode.
// - Mode fault drops controller select, disables outputs, aborts to idle.
// - Interrupt request rises when interrupt enable and mode fault are both set.
// - Controller waits a full serial period after loading before the first clock edge: half in lead, half in run.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module ssd_core (
  input wire logic CLOCK, // Bus clock
  input wire logic RST_N, // Asynchronous reset
  input wire logic CE, // Clock enable, freezes all state when low
  input wire logic [2:0] ADDR, // Register address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, cycle after the strobe
  output logic IRQ, // Interrupt request
  input wire logic SS_I, // Select pin level
  output logic SS_O, // Select drive value
  output logic SS_OE, // Select drive enable
  input wire logic SCK_I, // Serial clock pin level
  output logic SCK_O, // Serial clock drive value
  output logic SCK_OE, // Serial clock drive enable
  input wire logic MOSI_I, // Controller-out pin level
  output logic MOSI_O, // Controller-out drive value
  output logic MOSI_OE, // Controller-out drive enable
  input wire logic MISO_I, // Peripheral-out pin level
  output logic MISO_O, // Peripheral-out drive value
  output logic MISO_OE // Peripheral-out drive enable
);
  import ssd_pkg::*;

  // ----------------------------------------------------------------
  // Pin input filters
  // ----------------------------------------------------------------
  // A level is taken only once stages two and three agree
  wire [3:0] pin_raw = {SS_I, SCK_I, MOSI_I, MISO_I};
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          filt_reg[gi] <= 1'b1;
        end else if (CE) begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire ss_f = filt_reg[3];
  wire sck_f = filt_reg[2];
  wire mosi_f = filt_reg[1];
  wire miso_f = filt_reg[0];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] ctrl1_reg, ctrl2_reg, baud_reg;
  logic [7:0] rx_buf_reg, tx_buf_reg, sr_reg;
  logic rx_flag_reg, tx_empty_reg, fault_reg;
  logic rx_arm_reg, tx_arm_reg, fault_arm_reg;
  logic smp_reg, ph_reg, sck_prev_reg;
  logic [4:0] cnt_reg;
  logic [10:0] div_reg;
  ssd_state_e state_reg, state_next;

  wire int_en = ctrl1_reg[C1_INT_EN];
  wire port_en = ctrl1_reg[C1_PORT_EN];
  wire ctrl_sel = ctrl1_reg[C1_CTRL_SEL];
  wire idle_lvl = ctrl1_reg[C1_IDLE_LVL];
  wire edge_sel = ctrl1_reg[C1_EDGE_SEL];
  wire sel_out_en = ctrl1_reg[C1_SEL_OUT_EN];
  wire fault_en = ctrl2_reg[C2_FAULT_EN];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_c1 = WR && (ADDR == ADDR_CTRL1);
  wire wr_c2 = WR && (ADDR == ADDR_CTRL2);
  wire wr_bd = WR && (ADDR == ADDR_BAUD);
  wire rd_st = RD && (ADDR == ADDR_STATUS);
  wire rd_dt = RD && (ADDR == ADDR_DATA);
  wire wr_dt = WR && (ADDR == ADDR_DATA);

  wire [7:0] status_val = {rx_flag_reg, 1'b0, tx_empty_reg, fault_reg, 4'h0};
  logic [7:0] rd_val;
  always_comb begin
    if (ADDR == ADDR_CTRL1) begin
      rd_val = ctrl1_reg;
    end else if (ADDR == ADDR_CTRL2) begin
      rd_val = ctrl2_reg;
    end else if (ADDR == ADDR_BAUD) begin
      rd_val = baud_reg;
    end else if (ADDR == ADDR_STATUS) begin
      rd_val = status_val;
    end else if (ADDR == ADDR_DATA) begin
      rd_val = rx_buf_reg;
    end else begin
      rd_val = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Mode and transfer control
  // ----------------------------------------------------------------
  wire is_ctrl = port_en && ctrl_sel;
  wire is_peri = port_en && !ctrl_sel;
  wire fault = is_ctrl && fault_en && !sel_out_en && !ss_f;
  wire peri_sel = is_peri && !ss_f;
  // Setting changes in controller mode abort: the far end cannot follow them
  wire cfg_chg = is_ctrl && ((wr_c1 && (WDATA != ctrl1_reg)) ||
    (wr_c2 && (WDATA != ctrl2_reg)) || (wr_bd && ((WDATA & BAUD_MASK) != baud_reg)));
  wire peri_stop = !ctrl_sel && (ss_f || !port_en);
  wire abort = fault || cfg_chg || (peri_stop && (state_reg != ST_IDLE));

  wire [10:0] half_cnt = 11'({8'h00, baud_reg[6:4]} + 11'h001)
    << baud_reg[2:0];
  wire tick = (div_reg == (half_cnt - 11'h001));
  wire m_edge = is_ctrl && (state_reg == ST_RUN) && tick;
  wire s_edge = peri_sel && (state_reg == ST_RUN) && (sck_f != sck_prev_reg);
  wire edge_ev = m_edge || s_edge;
  wire [4:0] edge_no = cnt_reg + 5'h01;
  wire sample_edge = edge_sel ? !edge_no[0] : edge_no[0];
  wire first_edge = (edge_no == 5'h01);
  wire shift_edge = edge_ev && !sample_edge && !(edge_sel && first_edge);
  wire data_in = ctrl_sel ? miso_f : mosi_f;
  wire done = edge_ev && (edge_no == EDGES_PER_BYTE);
  wire [7:0] byte_in = {sr_reg[6:0], edge_sel ? data_in : smp_reg};

  wire start_ctrl = is_ctrl && (state_reg == ST_IDLE) && !tx_empty_reg && !fault;
  wire start_peri = peri_sel && (state_reg == ST_IDLE);
  wire load_tx = (start_ctrl || start_peri) && !tx_empty_reg;

  // Flag sequencing; a set in the same cycle as a clear wins
  wire rx_clr = rd_dt && rx_arm_reg;
  wire rx_take = done && (!rx_flag_reg || rx_clr);
  wire tx_load = wr_dt && tx_arm_reg;
  wire fault_clr = wr_c1 && fault_arm_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ctrl) begin
          state_next = ST_LEAD;
        end else if (start_peri) begin
          state_next = ST_RUN;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      div_reg <= 11'h000;
      cnt_reg <= 5'h00;
      ph_reg <= 1'b0;
      sr_reg <= 8'h00;
      smp_reg <= 1'b0;
      sck_prev_reg <= 1'b1;
    end else if (CE) begin
      state_reg <= state_next;
      sck_prev_reg <= sck_f;
      if ((state_next == ST_IDLE) || (state_reg == ST_IDLE) || tick) begin
        div_reg <= 11'h000;
      end else begin
        div_reg <= div_reg + 11'h001;
      end
      if (state_next == ST_IDLE || state_reg == ST_IDLE) begin
        cnt_reg <= 5'h00;
        ph_reg <= 1'b0;
      end else if (edge_ev) begin
        cnt_reg <= edge_no;
        ph_reg <= ph_reg ^ m_edge;
      end
      if (load_tx) begin
        sr_reg <= tx_buf_reg;
      end else if (done) begin
        sr_reg <= byte_in;
      end else if (shift_edge) begin
        sr_reg <= {sr_reg[6:0], smp_reg};
      end
      if (edge_ev && sample_edge) begin
        smp_reg <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
      baud_reg <= BAUD_RST;
      rx_buf_reg <= 8'h00;
      tx_buf_reg <= 8'h00;
      rx_flag_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      fault_reg <= 1'b0;
      rx_arm_reg <= 1'b0;
      tx_arm_reg <= 1'b0;
      fault_arm_reg <= 1'b0;
    end else if (CE) begin
      if (wr_c1) begin
        ctrl1_reg <= WDATA;
      end
      if (fault) begin
        ctrl1_reg[C1_CTRL_SEL] <= 1'b0;
      end
      if (wr_c2) begin
        ctrl2_reg <= WDATA;
      end
      if (wr_bd) begin
        baud_reg <= WDATA & BAUD_MASK;
      end
      if (rx_take) begin
        rx_buf_reg <= byte_in;
      end
      rx_flag_reg <= rx_take || (rx_flag_reg && !rx_clr);
      if (tx_load) begin
        tx_buf_reg <= WDATA;
      end
      tx_empty_reg <= load_tx || (tx_empty_reg && !tx_load);
      fault_reg <= fault || (fault_reg && !fault_clr);
      rx_arm_reg <= (rd_st && rx_flag_reg) || (rx_arm_reg && !rx_clr);
      tx_arm_reg <= (rd_st && tx_empty_reg) || (tx_arm_reg && !wr_dt);
      fault_arm_reg <= (rd_st && fault_reg) || (fault_arm_reg && !fault_clr);
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Pins lag the engine by one bus clock, no more than a serial half period
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      IRQ <= 1'b0;
      SS_O <= 1'b1;
      SS_OE <= 1'b0;
      SCK_O <= 1'b0;
      SCK_OE <= 1'b0;
      MOSI_O <= 1'b0;
      MOSI_OE <= 1'b0;
      MISO_O <= 1'b0;
      MISO_OE <= 1'b0;
    end else if (CE) begin
      RDATA <= RD ? rd_val : 8'h00;
      IRQ <= int_en && fault_reg;
      SS_O <= (state_reg == ST_IDLE);
      SS_OE <= is_ctrl && fault_en && sel_out_en && !fault;
      SCK_O <= idle_lvl ^ ph_reg;
      SCK_OE <= is_ctrl && !fault;
      MOSI_O <= sr_reg[7];
      MOSI_OE <= is_ctrl && !fault;
      MISO_O <= sr_reg[7];
      // A mode fault keeps peripheral-out off until software clears the flag
      MISO_OE <= peri_sel && !fault_reg && !fault;
    end
  end

endmodule

// ===== rtl/ssd_pkg.sv
// Constants shared by the byte-wide serial interface core.
// Assumes an 8-bit register port with a 3-bit byte address.
package ssd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_INT_EN = 7;
  localparam int C1_PORT_EN = 6;
  localparam int C1_CTRL_SEL = 4;
  localparam int C1_IDLE_LVL = 3;
  localparam int C1_EDGE_SEL = 2;
  localparam int C1_SEL_OUT_EN = 1;
  localparam int C2_FAULT_EN = 4;
  localparam int ST_RX_DONE = 7;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FAULT = 4;
  localparam int BAUD_PRE_LSB = 4;
  localparam logic [7:0] BAUD_MASK = 8'h77;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN = 2'b11
  } ssd_state_e;

endpackage

// ===== verification/ssd_core_sva.sv
// Port-level checks for the serial interface core.
// Assumes one bus clock domain and the register map of ssd_pkg.
`timescale 1ns/100ps
module ssd_core_sva
  import ssd_pkg::*;
(
  input wire logic CLOCK, // Bus clock
  input wire logic RST_N, // Async reset
  input wire logic [2:0] ADDR, // Address
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic [7:0] RDATA, // Read data
  input wire logic IRQ, // Interrupt
  input wire logic SS_O, // Select value
  input wire logic SS_OE, // Select enable
  input wire logic SCK_O, // Clock value
  input wire logic SCK_OE, // Clock enable
  input wire logic MOSI_OE, // Out enable
  input wire logic MISO_OE // In enable
);
  logic sck_q;
  logic ss_q;
  logic [5:0] edges;
  logic [5:0] edges_next;
  // Count clock toggles between select falling and rising
  assign edges_next = (ss_q && !SS_O) ? 6'h00 : edges + {5'h00, SCK_O != sck_q};
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
      edges <= 6'h00;
    end else begin
      sck_q <= SCK_O;
      ss_q <= SS_O;
      edges <= edges_next;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  chk_rdata_quiet:
    assert property (RDATA != 8'h00 |-> $past(RD)) else $error("read data out of slot");
  chk_status_unused:
    assert property ($past(RD) && $past(ADDR) == ADDR_STATUS |-> (RDATA & 8'h4F) == 8'h00)
    else $error("status spare bits set");
  chk_fault_outputs:
    assert property ($rose(IRQ) |-> ##[0:2] (!SCK_OE && !MOSI_OE && !MISO_OE))
    else $error("outputs still driven after fault");
  chk_irq_clear:
    assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2) || $past(WR, 3))
    else $error("interrupt dropped without a write");
  chk_sck_lead:
    assert property (SS_OE && $fell(SS_O) |-> $stable(SCK_O)) else $error("clock without lead");
  chk_sck_quiet:
    assert property (SS_OE && SS_O && $past(SS_O) |-> $stable(SCK_O))
    else $error("clock moved while idle");
  chk_edge_count:
    assert property (SS_OE && SS_O && !ss_q |-> edges_next == 6'h10)
    else $error("wrong clock edge count");
  chk_miso_off:
    assert property (SCK_OE |-> !MISO_OE) else $error("controller drives peripheral out");
endmodule
bind ssd_core ssd_core_sva u_sva (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR),
  .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .SS_O(SS_O), .SS_OE(SS_OE), .SCK_O(SCK_O),
  .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE));

// ===== verification/ssd_core_tb_top.sv
// Register-level bench: controller transfers against the peer, overrun and mode fault.
// Assumes the core, its package, checker and peer are compiled first.
`timescale 1ns/100ps
module ssd_core_tb_top;
  import ssd_pkg::*;
  logic clock;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ss_drv = 1'b1;
  logic [7:0] rdata;
  logic [7:0] p_got;
  logic irq, ss_o, ss_oe, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sdo;
  int p_count;
  int fails = 0;
  int checks = 0;
  // Undriven select follows ss_drv, clock and controller-out pulled down, peripheral-out from the peer
  wire ss_w = ss_oe ? ss_o : ss_drv;
  wire sck_w = sck_oe ? sck_o : 1'b0;
  wire mosi_w = mosi_oe ? mosi_o : 1'b0;
  wire miso_w = miso_oe ? miso_o : p_sdo;
  ssd_core dut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .SS_I(ss_w), .SS_O(ss_o), .SS_OE(ss_oe),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe));
  ssd_peer u_peer (.SEL_N(ss_w), .SCLK(sck_w), .SDI(mosi_w), .SDO(p_sdo), .GOT(p_got),
    .COUNT(p_count));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_peer(input int n);
    for (int i = 0; i < 3000 && p_count < n; i++) @(posedge clock);
    repeat (40) @(posedge clock);
    chk(8'(p_count), 8'(n));
  endtask
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 8'h20);
    wr_reg(ADDR_STATUS, 8'hFF);
    rd_chk(ADDR_STATUS, 8'h20);
    rd_chk(3'h4, 8'h00);
    wr_reg(ADDR_DATA, 8'hA5);
    wr_reg(ADDR_DATA, 8'h5A);
    rd_chk(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_BAUD, 8'h22);
    // Select is only driven with fault detection and select output both on
    wr_reg(ADDR_CTRL2, 8'h10);
    wr_reg(ADDR_CTRL1, 8'h52);
    repeat (2) @(posedge clock);
    chk({4'h0, ss_oe, sck_oe, mosi_oe, miso_oe}, 8'h0E);
    wait_peer(1);
    chk(p_got, 8'hA5);
    rd_chk(ADDR_STATUS, 8'hA0);
    rd_chk(ADDR_DATA, 8'h3C);
    rd_chk(ADDR_STATUS, 8'h20);
    wr_reg(ADDR_DATA, 8'h11);
    rd_chk(ADDR_STATUS, 8'h20);
    wr_reg(ADDR_DATA, 8'h22);
    wait_peer(3);
    chk(p_got, 8'h22);
    rd_chk(ADDR_DATA, 8'hA5);
    rd_chk(ADDR_STATUS, 8'hA0);
    rd_chk(ADDR_DATA, 8'hA5);
    rd_chk(ADDR_STATUS, 8'h20);
    wr_reg(ADDR_CTRL2, 8'h10);
    wr_reg(ADDR_CTRL1, 8'hD0);
    ss_drv <= 1'b0;
    repeat (10) @(posedge clock);
    chk({7'h00, irq}, 8'h01);
    rd_chk(ADDR_CTRL1, 8'hC0);
    rd_chk(ADDR_STATUS, 8'h30);
    @(posedge clock);
    ss_drv <= 1'b1;
    wr_reg(ADDR_CTRL1, 8'h00);
    rd_chk(ADDR_STATUS, 8'h20);
    chk({7'h00, irq}, 8'h00);
    conclude();
  end
endmodule

// ===== verification/ssd_peer.sv
// Far-side peripheral in format zero; echoes the byte it last received.
// Assumes the controller owns the clock and select lines.
`timescale 1ns/100ps
module ssd_peer (
  input wire logic SEL_N, // Select
  input wire logic SCLK, // Serial clock
  input wire logic SDI, // Data in
  output logic SDO, // Data out
  output logic [7:0] GOT, // Last byte
  output int COUNT // Bytes done
);
  logic [7:0] sh;
  logic [2:0] n;
  initial begin
    GOT = 8'h3C;
    COUNT = 0;
    SDO = 1'b0;
  end
  always @(negedge SEL_N) begin
    sh = GOT;
    n = 3'h0;
    SDO = sh[7];
  end
  // Sample on the rising edge, present on the falling one
  always @(posedge SCLK) if (!SEL_N) begin
    sh = {sh[6:0], SDI};
    n = n + 3'h1;
    if (n == 3'h0) begin
      GOT = sh;
      COUNT++;
    end
  end
  always @(negedge SCLK) if (!SEL_N) SDO = sh[7];
  // A released line must not keep its last value
  always @(posedge SEL_N) SDO = ~SDO;
endmodule
